// *** hdl/bss_pkg.sv ***
// Shared constants and types for the boot self-test supervisor
package bss_pkg;

    // ==============================================
    // Clock and timing
    // ==============================================
    localparam int unsigned CLK_HZ       = 20_000_000;
    // Host bring-up wait per attempt, in milliseconds
    localparam int unsigned HOST_WAIT_MS = 2000;
    localparam int unsigned HOST_WAIT_DEF_CYC =
        HOST_WAIT_MS * (CLK_HZ / 1000);
    // Host reset pulse between attempts, in microseconds
    localparam int unsigned HOST_RST_US  = 10;
    localparam logic [31:0] HOST_RST_CYC =
        32'(HOST_RST_US * (CLK_HZ / 1_000_000));

    // ==============================================
    // Sequence limits
    // ==============================================
    localparam logic [1:0] MAX_ATTEMPTS = 2'h3;  // Total tries
    localparam logic [2:0] TEST_FIRST   = 3'h0;  // Program sum
    localparam logic [2:0] TEST_LAST_P1 = 3'h4;  // Dual-port mem
    localparam logic [2:0] TEST_LAST    = 3'h6;  // Logic verify
    localparam logic [7:0] ESC_CHAR     = 8'h78; // Escape char
    localparam logic [1:0] ESC_LEN      = 2'h3;  // Chars needed

    // ==============================================
    // Serial report codes
    // ==============================================
    localparam logic [7:0] MSG_P1_DONE   = 8'h01;
    localparam logic [7:0] MSG_FPGA_DONE = 8'h02;
    localparam logic [7:0] MSG_HOST_TMO  = 8'h03;
    localparam logic [7:0] MSG_HOST_BAD  = 8'h04;
    localparam logic [7:0] MSG_HOST_OK   = 8'h05;
    localparam logic [7:0] MSG_UNRECOV   = 8'h06;
    localparam logic [7:0] MSG_REFUSED   = 8'h07;
    localparam logic [7:0] MSG_FALLBACK  = 8'h08;
    localparam logic [7:0] MSG_TEST_FAIL = 8'h10; // Or test index

    // ==============================================
    // Hex display codes and reset values
    // ==============================================
    localparam logic [7:0] HEX_IDLE      = 8'h00;
    localparam logic [7:0] HEX_TEST      = 8'h10; // Or test index
    localparam logic [7:0] HEX_HOST_WAIT = 8'h20; // Or attempt
    localparam logic [7:0] HEX_RUN       = 8'h30;
    localparam logic [7:0] HEX_FAIL_TEST = 8'he0; // Or test index
    localparam logic [7:0] HEX_FAIL_TMO  = 8'hf1;
    localparam logic [7:0] HEX_FAIL_BAD  = 8'hf2;
    localparam logic [7:0] RST_HEX       = HEX_IDLE;
    localparam logic [7:0] RST_MSG       = 8'h00;

    // ==============================================
    // Supervisor states
    // ==============================================
    typedef enum logic [2:0] {
        ST_HOLD      = 3'b000,
        ST_TEST      = 3'b001,
        ST_WAIT_TEST = 3'b010,
        ST_RELEASE   = 3'b011,
        ST_WAIT_HOST = 3'b100,
        ST_RETRY     = 3'b101,
        ST_RUN       = 3'b110,
        ST_FAIL      = 3'b111
    } bss_state_type;

endpackage

// *** hdl/bss_esc_detect.sv ***
// Escape sequence detector on the received serial byte stream
`timescale 1ns/1ns
`default_nettype none

module bss_esc_detect
    import bss_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       clear_i,
    input  wire logic       rx_valid_i,
    input  wire logic [7:0] rx_byte_i,
    output var  logic       hit_o
);

    // ==============================================
    // Run counter
    // ==============================================
    logic [1:0] run_cnt; // Escape chars seen in a row

    // Any other byte breaks the run, so line noise rarely matches
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || clear_i)
        begin
            run_cnt <= 2'h0;
        end
        else if (rx_valid_i)
        begin
            if (rx_byte_i != ESC_CHAR)
            begin
                run_cnt <= 2'h0;
            end
            else if (run_cnt == ESC_LEN - 2'h1)
            begin
                run_cnt <= 2'h0;
            end
            else
            begin
                run_cnt <= run_cnt + 2'h1;
            end
        end
    end

    // One-cycle hit on the final escape char
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || clear_i)
        begin
            hit_o <= 1'b0;
        end
        else
        begin
            hit_o <= rx_valid_i && rx_byte_i == ESC_CHAR &&
                     run_cnt == ESC_LEN - 2'h1;
        end
    end

endmodule
`default_nettype wire

// *** hdl/bss_supervisor.sv ***
// Boot self-test supervisor: host reset, tests, reports, handover
`timescale 1ns/1ns
`default_nettype none

module bss_supervisor
    import bss_pkg::*;
#(
    parameter int unsigned HOST_WAIT_CYC = HOST_WAIT_DEF_CYC
)
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       test_done_i,
    input  wire logic       test_pass_i,
    input  wire logic       host_msg_stb_i,
    input  wire logic       host_msg_ok_i,
    input  wire logic       host_app_fail_i,
    input  wire logic       rx_valid_i,
    input  wire logic [7:0] rx_byte_i,
    input  wire logic       link_reset_i,
    input  wire logic       warm_reboot_cmd_i,
    input  wire logic       out_of_service_state_i,
    output var  logic       test_req_o,
    output var  logic [2:0] test_sel_o,
    output var  logic       host_reset_o,
    output var  logic       msg_stb_o,
    output var  logic [7:0] msg_code_o,
    output var  logic       msg_to_link_o,
    output var  logic       host_serial_route_o,
    output var  logic [7:0] hex_o,
    output var  logic       fallback_boot_o,
    output var  logic       card_failed_o
);

    // Last cycle of one host wait
    localparam logic [31:0] WAIT_LAST = 32'(HOST_WAIT_CYC - 1);

    // Base code with a small index merged into the low bits
    function automatic logic [7:0] with_idx(
        input logic [7:0] base,
        input logic [2:0] idx
    );
        return base | {5'h00, idx};
    endfunction

    // ==============================================
    // Pin synchronisers
    // ==============================================
    logic [5:0] sync_a;  // First stage, read by sync_b only
    logic [5:0] sync_b;  // Safe copy of the pins
    logic [5:0] sync_c;  // Previous safe copy, for edges

    // Host and link pins come from other clock domains
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
            sync_c <= 6'h00;
        end
        else
        begin
            sync_a <= {host_msg_stb_i, host_msg_ok_i,
                       host_app_fail_i, link_reset_i,
                       warm_reboot_cmd_i, out_of_service_state_i};
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    logic host_rise;   // New host status message
    logic host_ok;     // Message says all circuits good
    logic app_rise;    // Host application failed to start
    logic link_rise;   // Remote reset over the link
    logic reboot_rise; // Warm reboot command
    logic out_of_service_state;         // Card is out of service
    logic restart;     // Whole sequence starts over

    assign host_rise   = sync_b[5] && !sync_c[5];
    assign host_ok     = sync_b[4];
    assign app_rise    = sync_b[3] && !sync_c[3];
    assign link_rise   = sync_b[2] && !sync_c[2];
    assign reboot_rise = sync_b[1] && !sync_c[1];
    assign out_of_service_state         = sync_b[0];
    // Reboot is ignored while in service
    assign restart     = link_rise || (reboot_rise && out_of_service_state);

    // ==============================================
    // Main sequencer
    // ==============================================
    bss_state_type state;    // Sequencer state
    logic [2:0]    tsel;     // Current test index
    logic [1:0]    attempts; // Host bring-up tries so far
    logic [31:0]   tmr;      // Wait and reset-pulse timer

    // Events seen by reporting and display
    logic ev_test_fail;
    logic ev_tmo;
    logic ev_bad;
    logic ev_ok;
    logic host_fault;

    assign ev_test_fail = !restart && state == ST_WAIT_TEST &&
                          test_done_i && !test_pass_i;
    assign ev_ok  = !restart && state == ST_WAIT_HOST &&
                    host_rise && host_ok;
    assign ev_bad = !restart && state == ST_WAIT_HOST &&
                    host_rise && !host_ok;
    assign ev_tmo = !restart && state == ST_WAIT_HOST &&
                    !host_rise && tmr == WAIT_LAST;
    assign host_fault = ev_bad || ev_tmo;

    // State, test index, attempts and timer
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || restart)
        begin
            state    <= ST_HOLD;
            tsel     <= TEST_FIRST;
            attempts <= 2'h0;
            tmr      <= 32'h0;
        end
        else
        begin
            unique case (state)
                ST_HOLD:
                begin
                    tsel  <= TEST_FIRST;
                    state <= ST_TEST;
                end
                ST_TEST:
                begin
                    state <= ST_WAIT_TEST;
                end
                ST_WAIT_TEST:
                begin
                    // Any failing test stops before the host
                    if (test_done_i && !test_pass_i)
                    begin
                        state <= ST_FAIL;
                    end
                    else if (test_done_i && tsel == TEST_LAST)
                    begin
                        state <= ST_RELEASE;
                    end
                    else if (test_done_i)
                    begin
                        tsel  <= tsel + 3'h1;
                        state <= ST_TEST;
                    end
                end
                ST_RELEASE:
                begin
                    attempts <= attempts + 2'h1;
                    tmr      <= 32'h0;
                    state    <= ST_WAIT_HOST;
                end
                ST_WAIT_HOST:
                begin
                    tmr <= tmr + 32'h1;
                    if (ev_ok)
                    begin
                        state <= ST_RUN;
                    end
                    else if (host_fault)
                    begin
                        tmr <= 32'h0;
                        // Third failure is final
                        if (attempts == MAX_ATTEMPTS)
                        begin
                            state <= ST_FAIL;
                        end
                        else
                        begin
                            state <= ST_RETRY;
                        end
                    end
                end
                ST_RETRY:
                begin
                    // Host held in reset for a short pulse
                    tmr <= tmr + 32'h1;
                    if (tmr == HOST_RST_CYC - 32'h1)
                    begin
                        state <= ST_RELEASE;
                    end
                end
                ST_RUN:
                begin
                    state <= ST_RUN;
                end
                ST_FAIL:
                begin
                    state <= ST_FAIL;  // Left only by restart
                end
            endcase
        end
    end

    // ==============================================
    // Test engine request
    // ==============================================
    // One-cycle request per test; engine answers with done
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            test_req_o <= 1'b0;
            test_sel_o <= TEST_FIRST;
        end
        else
        begin
            test_req_o <= state == ST_TEST && !restart;
            test_sel_o <= tsel;
        end
    end

    // ==============================================
    // Host reset and serial routing
    // ==============================================
    // Host runs only between release and a failure or restart
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            host_reset_o <= 1'b1;
        end
        else
        begin
            host_reset_o <= !(state == ST_RELEASE ||
                              state == ST_WAIT_HOST ||
                              state == ST_RUN);
        end
    end

    // Port stays on the faceplate until the host answers well
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            msg_to_link_o       <= 1'b0;
            host_serial_route_o <= 1'b0;
        end
        else
        begin
            msg_to_link_o       <= state == ST_RUN;
            host_serial_route_o <= state == ST_RUN;
        end
    end

    // ==============================================
    // Boot fallback
    // ==============================================
    logic esc_hit;  // Escape sequence just completed
    logic booting;  // Host is between reset and success

    assign booting = state == ST_RELEASE ||
                     state == ST_WAIT_HOST ||
                     state == ST_RETRY;

    bss_esc_detect u_esc (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .clear_i    (!booting),
        .rx_valid_i (rx_valid_i),
        .rx_byte_i  (rx_byte_i),
        .hit_o      (esc_hit)
    );

    // Sticky until restart; the host reads it at its next boot
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || restart)
        begin
            fallback_boot_o <= 1'b0;
        end
        else if (esc_hit && booting)
        begin
            fallback_boot_o <= 1'b1;
        end
        else if (app_rise && state != ST_HOLD)
        begin
            fallback_boot_o <= 1'b1;
        end
    end

    // ==============================================
    // Serial report messages
    // ==============================================
    logic fail_said; // Unrecoverable report already sent

    // One code per cycle; faults win over routine notices
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || restart)
        begin
            msg_stb_o  <= 1'b0;
            msg_code_o <= RST_MSG;
            fail_said  <= 1'b0;
        end
        else
        begin
            msg_stb_o <= 1'b1;
            if (ev_test_fail)
            begin
                msg_code_o <= with_idx(MSG_TEST_FAIL, tsel);
            end
            else if (ev_tmo)
            begin
                msg_code_o <= MSG_HOST_TMO;
            end
            else if (ev_bad)
            begin
                msg_code_o <= MSG_HOST_BAD;
            end
            else if (ev_ok)
            begin
                msg_code_o <= MSG_HOST_OK;
            end
            else if (state == ST_WAIT_TEST && test_done_i &&
                     tsel == TEST_LAST_P1)
            begin
                msg_code_o <= MSG_P1_DONE;
            end
            else if (state == ST_WAIT_TEST && test_done_i &&
                     tsel == TEST_LAST)
            begin
                msg_code_o <= MSG_FPGA_DONE;
            end
            else if (state == ST_FAIL && !fail_said)
            begin
                msg_code_o <= MSG_UNRECOV;
                fail_said  <= 1'b1;
            end
            else if (reboot_rise && !out_of_service_state)
            begin
                msg_code_o <= MSG_REFUSED;
            end
            else if (esc_hit && booting)
            begin
                msg_code_o <= MSG_FALLBACK;
            end
            else
            begin
                msg_stb_o <= 1'b0;
            end
        end
    end

    // ==============================================
    // Hex display and failure flag
    // ==============================================
    logic fail_latched; // First failure code is on display

    // Progress until the first fault, then frozen on its code
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || restart)
        begin
            hex_o        <= RST_HEX;
            fail_latched <= 1'b0;
        end
        else if (!fail_latched)
        begin
            fail_latched <= ev_test_fail || host_fault;
            if (ev_test_fail)
            begin
                hex_o <= with_idx(HEX_FAIL_TEST, tsel);
            end
            else if (ev_tmo)
            begin
                hex_o <= HEX_FAIL_TMO;
            end
            else if (ev_bad)
            begin
                hex_o <= HEX_FAIL_BAD;
            end
            else if (state == ST_TEST)
            begin
                hex_o <= with_idx(HEX_TEST, tsel);
            end
            else if (state == ST_WAIT_HOST)
            begin
                hex_o <= with_idx(HEX_HOST_WAIT, {1'b0, attempts});
            end
            else if (state == ST_RUN)
            begin
                hex_o <= HEX_RUN;
            end
        end
    end

    // Card is dead until a remote or warm reset
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            card_failed_o <= 1'b0;
        end
        else
        begin
            card_failed_o <= state == ST_FAIL;
        end
    end

    // ==============================================
    // Checks
    // ==============================================
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    a_host_held_tests: assert property (
        state inside {ST_TEST, ST_WAIT_TEST} |-> host_reset_o)
        else $error("host left running during self-test");

    a_release_after_tests: assert property (
        $fell(host_reset_o) |->
            $past(state) == ST_RELEASE && tsel == TEST_LAST)
        else $error("host released before all tests passed");

    a_timeout_report: assert property (
        ev_tmo |=> msg_stb_o && msg_code_o == MSG_HOST_TMO)
        else $error("host timeout not reported");

    a_final_timeout: assert property (
        ev_tmo && attempts == MAX_ATTEMPTS |=>
            state == ST_FAIL ##1 card_failed_o)
        else $error("third timeout did not end in failure");

    a_attempt_bound: assert property (
        attempts != 2'h0 |-> attempts <= MAX_ATTEMPTS &&
            $stable(attempts) || $past(state) == ST_RELEASE)
        else $error("attempt counter moved outside release");

    a_bad_msg_retry: assert property (
        ev_bad && attempts < MAX_ATTEMPTS |=>
            state == ST_RETRY ##1 host_reset_o)
        else $error("faulty host not reset again");

    a_bad_msg_report: assert property (
        ev_bad |=> msg_stb_o && msg_code_o == MSG_HOST_BAD)
        else $error("host fault message not reported");

    a_handover_route: assert property (
        host_serial_route_o == msg_to_link_o and
        ($rose(msg_to_link_o) |-> $past(state) == ST_RUN))
        else $error("serial handover without host success");

    a_hex_first_fail: assert property (
        fail_latched && !restart |=> $stable(hex_o))
        else $error("first failure code overwritten");

    a_phase_report: assert property (
        !restart && state == ST_WAIT_TEST && test_done_i &&
        test_pass_i && tsel == TEST_LAST_P1 |=>
            msg_code_o == MSG_P1_DONE && msg_stb_o)
        else $error("first phase end not reported");

    a_remote_reset: assert property (
        link_rise |=> state == ST_HOLD ##1 host_reset_o)
        else $error("remote reset not obeyed");

    a_escape_fallback: assert property (
        esc_hit && booting && !restart |=> fallback_boot_o)
        else $error("escape sequence did not force fallback");

    a_reboot_oos_only: assert property (
        reboot_rise && !out_of_service_state && !link_rise && state != ST_HOLD
            |=> state != ST_HOLD)
        else $error("warm reboot taken while in service");

endmodule
`default_nettype wire

// *** dv/bss_far_model.sv ***
// Far side model: self-test engine and host processor bring-up
`timescale 1ns/1ns
`default_nettype none

module bss_far_model (
    input  wire logic       core_clk_i,
    input  wire logic       test_req_i,
    input  wire logic [2:0] test_sel_i,
    input  wire logic       host_reset_i,
    input  wire logic [5:0] plan_i,     // Per attempt: 0 ok, 1 bad, 2 mute
    output var  logic       test_done_o,
    output var  logic       host_msg_stb_o,
    output var  logic       host_msg_ok_o
);
    logic [1:0] idx  = 2'h0;  // Host attempt number
    logic [3:0] dly  = 4'h0;  // Host boot time left
    logic [2:0] hold = 3'h0;  // Strobe cycles left
    logic       prev = 1'b1;  // Host reset last cycle

    // Engine answers one cycle after each request
    always @(posedge core_clk_i)
        test_done_o <= test_req_i;

    // Host answers a while after release, as the plan commands
    always @(posedge core_clk_i)
    begin
        prev <= host_reset_i;
        if (test_req_i && test_sel_i == 3'h0)
            idx <= 2'h0;
        if (prev && !host_reset_i)
            dly <= 4'h9;
        else if (dly != 4'h0)
        begin
            dly <= dly - 4'h1;
            if (dly == 4'h1)
            begin
                idx <= idx + 2'h1;
                if (plan_i[2*idx+:2] != 2'h2)
                begin
                    // Strobe held 4 cycles, low long after
                    host_msg_ok_o  <= plan_i[2*idx+:2] == 2'h0;
                    host_msg_stb_o <= 1'b1;
                    hold           <= 3'h4;
                end
            end
        end
        if (hold == 3'h1)
        begin
            // Released status line no longer shows the old value
            host_msg_stb_o <= 1'b0;
            host_msg_ok_o  <= ~host_msg_ok_o;
        end
        if (hold != 3'h0)
            hold <= hold - 3'h1;
    end

    initial
    begin
        test_done_o    = 1'b0;
        host_msg_stb_o = 1'b0;
        host_msg_ok_o  = 1'b0;
    end
endmodule

`default_nettype wire

// *** dv/bss_supervisor_test.sv ***
// Self-checking testbench for the boot self-test supervisor
`timescale 1ns/1ns
`default_nettype none

module bss_supervisor_test
    import bss_pkg::*;
;
    logic core_clk_i = 1'b0, rst_i = 1'b1, rx_valid_i = 1'b0;
    logic link_reset_i = 1'b0, warm_reboot_cmd_i = 1'b0;
    logic out_of_service_state_i = 1'b0;
    logic [7:0] rx_byte_i = 8'h00, msg_code_o, hex_o;
    logic [5:0] plan = 6'h00;
    logic [2:0] test_sel_o, sel_exp = 3'h0;
    logic test_done_i, host_msg_stb_i, host_msg_ok_i, test_req_o;
    logic host_reset_o, msg_stb_o, msg_to_link_o, host_serial_route_o;
    logic fallback_boot_o, card_failed_o, host_app_fail_i = 1'b0;
    logic [2:0] fail_sel = 3'h7;  // Test index the engine fails
    wire  test_pass_i = test_sel_o != fail_sel;
    logic [7:0] exp_q[$];  // Expected report codes, oldest first
    logic [31:0] rnd = 32'h24;
    int n_errors = 0;
    int n_compared = 0;

    always #25 core_clk_i = ~core_clk_i;

    // Short host wait keeps the three-attempt run brief
    bss_supervisor #(.HOST_WAIT_CYC(64)) bss_supervisor_inst (
        .core_clk_i, .rst_i, .test_done_i, .test_pass_i,
        .host_msg_stb_i, .host_msg_ok_i, .host_app_fail_i,
        .rx_valid_i, .rx_byte_i, .link_reset_i, .warm_reboot_cmd_i,
        .out_of_service_state_i, .test_req_o, .test_sel_o, .host_reset_o,
        .msg_stb_o, .msg_code_o, .msg_to_link_o, .host_serial_route_o,
        .hex_o, .fallback_boot_o, .card_failed_o);

    bss_far_model bss_far_model_inst (
        .core_clk_i, .test_req_i(test_req_o), .test_sel_i(test_sel_o),
        .host_reset_i(host_reset_o), .plan_i(plan),
        .test_done_o(test_done_i), .host_msg_stb_o(host_msg_stb_i),
        .host_msg_ok_o(host_msg_ok_i));

    // ==========================================================
    // Checking
    // ==========================================================
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Each report is matched with the oldest note; tests must run in order
    always @(negedge core_clk_i)
    begin
        if (msg_stb_o === 1'b1)
            check("msg_code_o", msg_code_o,
                  exp_q.size() != 0 ? exp_q.pop_front() : 8'hff);
        if (test_req_o === 1'b1)
        begin
            check("test_sel_o", {5'h00, test_sel_o}, {5'h00, sel_exp});
            sel_exp = sel_exp == TEST_LAST ? 3'h0 : sel_exp + 3'h1;
        end
    end

    task automatic tick(int n);
        repeat (n) @(posedge core_clk_i);
        #5;
    endtask

    // Waits, bounded, until every expected report has been seen
    task automatic drain();
        for (int i = 0; i < 3000 && exp_q.size() != 0; i++)
            tick(1);
        check("pending", 8'(exp_q.size()), 8'h00);
        tick(2);
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    initial
    begin
        // Clean boot, handover, refused then accepted warm reboot
        exp_q = '{MSG_P1_DONE, MSG_FPGA_DONE, MSG_HOST_OK};
        tick(10);
        check("host_reset_o", host_reset_o, 8'h01);
        check("hex_o", hex_o, RST_HEX);
        rst_i = 1'b0;
        tick(3);
        check("host_reset_o", host_reset_o, 8'h01);
        drain();
        check("msg_to_link_o", msg_to_link_o, 8'h01);
        check("host_serial_route_o", host_serial_route_o, 8'h01);
        check("hex_o", hex_o, HEX_RUN);
        exp_q.push_back(MSG_REFUSED);
        warm_reboot_cmd_i = 1'b1;
        tick(4);
        warm_reboot_cmd_i = 1'b0;
        drain();
        check("host_reset_o", host_reset_o, 8'h00);
        exp_q = '{MSG_P1_DONE, MSG_FPGA_DONE, MSG_HOST_OK};
        out_of_service_state_i = 1'b1;
        warm_reboot_cmd_i = 1'b1;
        tick(4);
        warm_reboot_cmd_i = 1'b0;
        check("host_reset_o", host_reset_o, 8'h01);
        drain();
        out_of_service_state_i = 1'b0;
        // Remote restart; bad message, timeout, then success
        plan = 6'h09;
        exp_q = '{MSG_P1_DONE, MSG_FPGA_DONE, MSG_HOST_BAD, MSG_HOST_TMO,
                  MSG_HOST_OK};
        link_reset_i = 1'b1;
        tick(4);
        link_reset_i = 1'b0;
        drain();
        check("hex_o", hex_o, HEX_FAIL_BAD);
        check("msg_to_link_o", msg_to_link_o, 8'h01);
        check("fallback_boot_o", fallback_boot_o, 8'h00);
        host_app_fail_i = 1'b1;
        tick(4);
        host_app_fail_i = 1'b0;
        check("fallback_boot_o", fallback_boot_o, 8'h01);
        // Mute host three times, escape typed with a broken run first
        plan = 6'h2a;
        exp_q = '{MSG_P1_DONE, MSG_FPGA_DONE, MSG_FALLBACK, MSG_HOST_TMO,
                  MSG_HOST_TMO, MSG_HOST_TMO, MSG_UNRECOV};
        rst_i = 1'b1;
        tick(4);
        rst_i = 1'b0;
        for (int i = 0; i < 2000 && host_reset_o !== 1'b0; i++)
            tick(1);
        for (int i = 0; i < 6; i++)
        begin
            rnd = xs(rnd);
            rx_byte_i = i == 2 ? (rnd[7:0] | 8'h80) : ESC_CHAR;
            rx_valid_i = 1'b1;
            tick(1);
            rx_valid_i = 1'b0;
            tick(1);
        end
        drain();
        check("fallback_boot_o", fallback_boot_o, 8'h01);
        check("card_failed_o", card_failed_o, 8'h01);
        check("hex_o", hex_o, HEX_FAIL_TMO);
        // Fourth test fails: host never released, failure code held
        fail_sel = 3'h3;
        exp_q = '{MSG_TEST_FAIL | 8'h03, MSG_UNRECOV};
        rst_i = 1'b1;
        tick(4);
        rst_i = 1'b0;
        drain();
        check("hex_o", hex_o, HEX_FAIL_TEST | 8'h03);
        check("host_reset_o", host_reset_o, 8'h01);
        check("card_failed_o", card_failed_o, 8'h01);
        summarize();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        n_errors++;
        summarize();
    end
endmodule

`default_nettype wire
